// ==== design/sdbw_pair_ctrl.sv ====
// Serializer/deserializer pair control: self test, remote wake-up, power-down, edge select, GPIO
`timescale 1ns/1ps
`default_nettype none
`include "sdbw_defs.svh"
module sdbw_pair_ctrl #(
	parameter int DATA_W = 16,
	parameter int CNT_W = 8
) (
	// Clocks and reset
	input wire logic CORE_CLK_I,
	input wire logic LINK_CLK_I,
	input wire logic SYS_RST_I,
	// Register port from the control slave
	input wire sdbw_pkg::sdbw_reg_req_t REG_REQ_I,
	output logic [7:0] REG_RDATA_O,
	// Pins and straps
	input wire logic SELF_TEST_RUN_PIN_I,
	input wire logic DES_PWRDN_N_I,
	input wire logic SER_PWRDN_N_I,
	input wire logic CAMERA_MODE_I,
	input wire logic [4:0] BUS_WIDTH_I,
	input wire logic OUTPUT_IDLE_STATE_SELECT_I,
	input wire logic SER_LATCH_EDGE_SELECT_I,
	input wire logic DES_STROBE_EDGE_SELECT_I,
	input wire logic SER_PCLK_PRESENT_I,
	input wire logic BC_ERR_I,
	// GPIO
	input wire sdbw_pkg::sdbw_gpio_t GPIO_I,
	output logic [5:0] GPIO_O,
	output logic [5:0] GPIO_OE_O,
	output logic [5:0] GPIO_AVAIL_O,
	output logic [5:0] GPIO_TO_SER_O,
	// Power, wake and test status
	output logic LOCK_O,
	output logic REMOTE_WAKE_O,
	output logic [7:0] BC_DRV_MODE_O,
	output logic [1:0] SER_STATE_O,
	output logic SER_USE_OSC_O,
	output logic BUILT_IN_SELF_TEST_SER_CMD_O,
	output logic [1:0] BUILT_IN_SELF_TEST_CLK_SEL_O,
	output logic SER_GPIO0_O,
	output logic [CNT_W-1:0] SER_ERR_COUNT_O,
	output logic [CNT_W-1:0] ERR_COUNT_O,
	output logic SER_LATCH_RISE_O,
	output logic DES_PCLK_INV_O,
	// Link side
	input wire logic [DATA_W-1:0] LINK_WORD_I,
	input wire logic LINK_CDR_LOCK_I,
	input wire logic [DATA_W-1:0] SER_PAR_DATA_I,
	output logic [DATA_W-1:0] SER_TX_WORD_O,
	output logic [DATA_W-1:0] DES_PAR_DATA_O,
	output logic DES_PAR_OE_O,
	output logic PASS_O
);
	import sdbw_pkg::*;

	localparam int GPIO_CYC = `SDBW_GPIO_CYC;

	function automatic logic [14:0] prbs_step(input logic [14:0] s);
		logic [14:0] r;
		r = s;
		for (int i = 0; i < DATA_W; i++) begin
			r = {r[13:0], r[14] ^ r[13]};
		end
		return r;
	endfunction

	// Pin synchronisers, two flops each
	logic [1:0] built_in_self_test_sq, dpd_sq, spd_sq, pclk_sq, lock_sq, bce_sq;
	logic [5:0] gin_m_q, gin_s_q;
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			built_in_self_test_sq <= 2'h0;
			dpd_sq <= 2'h0;
			// Pin idles released; avoids a false power-down right after reset
			spd_sq <= 2'h3;
			pclk_sq <= 2'h0;
			lock_sq <= 2'h0;
			bce_sq <= 2'h0;
			gin_m_q <= 6'h00;
			gin_s_q <= 6'h00;
		end else begin
			built_in_self_test_sq <= {built_in_self_test_sq[0], SELF_TEST_RUN_PIN_I};
			dpd_sq <= {dpd_sq[0], DES_PWRDN_N_I};
			spd_sq <= {spd_sq[0], SER_PWRDN_N_I};
			pclk_sq <= {pclk_sq[0], SER_PCLK_PRESENT_I};
			lock_sq <= {lock_sq[0], LINK_CDR_LOCK_I};
			bce_sq <= {bce_sq[0], BC_ERR_I};
			gin_m_q <= GPIO_I.pin_in;
			gin_s_q <= gin_m_q;
		end
	end
	logic built_in_self_test_s, dpd_s, spd_s, pclk_s, lock_s, bce_s;
	assign built_in_self_test_s = built_in_self_test_sq[1];
	assign dpd_s = dpd_sq[1];
	assign spd_s = spd_sq[1];
	assign pclk_s = pclk_sq[1];
	assign lock_s = lock_sq[1];
	assign bce_s = bce_sq[1];

	// Registers
	logic [7:0] wake_q, bcdrv_q;
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			wake_q <= `SDBW_REG_WAKE_RST;
			bcdrv_q <= `SDBW_REG_BCDRV_RST;
			REG_RDATA_O <= 8'h00;
		end else begin
			if (REG_REQ_I.wr && REG_REQ_I.addr == `SDBW_REG_WAKE_OFS) begin
				wake_q <= REG_REQ_I.wdata;
			end
			if (REG_REQ_I.wr && REG_REQ_I.addr == `SDBW_REG_BCDRV_OFS) begin
				bcdrv_q <= REG_REQ_I.wdata;
			end
			case (REG_REQ_I.addr)
				`SDBW_REG_WAKE_OFS: REG_RDATA_O <= wake_q;
				`SDBW_REG_BCDRV_OFS: REG_RDATA_O <= bcdrv_q;
				default: REG_RDATA_O <= 8'h00;
			endcase
		end
	end

	// Wake and back channel driver mode go out as levels; host sequencing is its own job
	logic wake_lvl;
	assign wake_lvl = wake_q[`SDBW_WAKE_BIT] && CAMERA_MODE_I;
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			REMOTE_WAKE_O <= 1'b0;
			BC_DRV_MODE_O <= `SDBW_REG_BCDRV_RST;
		end else begin
			REMOTE_WAKE_O <= wake_lvl;
			BC_DRV_MODE_O <= bcdrv_q;
		end
	end

	// Serializer power state
	sdbw_ser_state_t ser_q;
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ser_q <= SDBW_SER_STANDBY;
		end else if (!spd_s) begin
			ser_q <= SDBW_SER_OFF;
		end else begin
			case (ser_q)
				SDBW_SER_OFF: ser_q <= SDBW_SER_STANDBY;
				SDBW_SER_STANDBY: begin
					if (wake_lvl) begin
						ser_q <= pclk_s ? SDBW_SER_ACT_PCLK : SDBW_SER_ACT_OSC;
					end
				end
				SDBW_SER_ACT_PCLK, SDBW_SER_ACT_OSC: begin
					if (!wake_lvl) begin
						ser_q <= SDBW_SER_STANDBY;
					end else begin
						ser_q <= pclk_s ? SDBW_SER_ACT_PCLK : SDBW_SER_ACT_OSC;
					end
				end
				default: ser_q <= SDBW_SER_STANDBY;
			endcase
		end
	end
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			SER_STATE_O <= 2'h1;
			SER_USE_OSC_O <= 1'b0;
		end else begin
			SER_STATE_O <= ser_q;
			SER_USE_OSC_O <= (ser_q == SDBW_SER_ACT_OSC);
		end
	end

	// Deserializer power state; auto mode follows the recovered stream
	sdbw_des_state_t des_q;
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			des_q <= SDBW_DES_OFF;
		end else begin
			case (des_q)
				SDBW_DES_OFF: des_q <= dpd_s ? SDBW_DES_DOWN : SDBW_DES_OFF;
				SDBW_DES_DOWN: begin
					if (!dpd_s) begin
						des_q <= SDBW_DES_OFF;
					end else if (lock_s) begin
						des_q <= SDBW_DES_LOCKED;
					end
				end
				SDBW_DES_LOCKED: begin
					if (!dpd_s) begin
						des_q <= SDBW_DES_OFF;
					end else if (!lock_s) begin
						des_q <= SDBW_DES_DOWN;
					end
				end
				default: des_q <= SDBW_DES_OFF;
			endcase
		end
	end
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			LOCK_O <= 1'b0;
		end else begin
			LOCK_O <= (des_q == SDBW_DES_LOCKED);
		end
	end

	// Self test control
	logic run_q, built_in_self_test_d1_q;
	logic built_in_self_test_start;
	assign built_in_self_test_start = CAMERA_MODE_I && built_in_self_test_s && !built_in_self_test_d1_q;
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			built_in_self_test_d1_q <= 1'b0;
			BUILT_IN_SELF_TEST_SER_CMD_O <= 1'b0;
			BUILT_IN_SELF_TEST_CLK_SEL_O <= 2'h0;
			run_q <= 1'b0;
		end else begin
			built_in_self_test_d1_q <= built_in_self_test_s;
			BUILT_IN_SELF_TEST_SER_CMD_O <= CAMERA_MODE_I && built_in_self_test_s;
			if (built_in_self_test_start) begin
				BUILT_IN_SELF_TEST_CLK_SEL_O <= gin_s_q[1:0];
			end
			run_q <= CAMERA_MODE_I && built_in_self_test_s && des_q == SDBW_DES_LOCKED;
		end
	end

	// Serializer back channel indicator and its own error count
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			SER_GPIO0_O <= 1'b1;
			SER_ERR_COUNT_O <= '0;
		end else begin
			SER_GPIO0_O <= !(run_q && bce_s);
			if (built_in_self_test_start || !spd_s) begin
				SER_ERR_COUNT_O <= '0;
			end else if (run_q && bce_s && SER_ERR_COUNT_O != '1) begin
				SER_ERR_COUNT_O <= SER_ERR_COUNT_O + 1'b1;
			end
		end
	end

	// GPIO availability, direction and rate limit toward the serializer
	logic [11:0] rate_cnt_q;
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			GPIO_AVAIL_O <= 6'h03;
			GPIO_O <= 6'h00;
			GPIO_OE_O <= 6'h00;
			GPIO_TO_SER_O <= 6'h00;
			rate_cnt_q <= 12'h000;
		end else begin
			GPIO_AVAIL_O <= {(BUS_WIDTH_I < 5'(`SDBW_NARROW_BUS_BITS)) ? 4'hf : 4'h0, 2'h3};
			GPIO_O <= GPIO_I.from_ser & GPIO_AVAIL_O;
			GPIO_OE_O <= GPIO_I.dir_out & GPIO_AVAIL_O;
			// Slow sampling keeps the back channel within its update budget
			if (rate_cnt_q == 12'(GPIO_CYC - 1)) begin
				rate_cnt_q <= 12'h000;
				GPIO_TO_SER_O <= gin_s_q & ~GPIO_I.dir_out & GPIO_AVAIL_O;
			end else begin
				rate_cnt_q <= rate_cnt_q + 12'h001;
			end
		end
	end

	// Edge selects; 1 means rising edge
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			SER_LATCH_RISE_O <= 1'b0;
			DES_PCLK_INV_O <= 1'b0;
		end else begin
			SER_LATCH_RISE_O <= SER_LATCH_EDGE_SELECT_I;
			DES_PCLK_INV_O <= !DES_STROBE_EDGE_SELECT_I;
		end
	end

	// Link domain reset: asserted at once, released on the link clock
	logic [1:0] lrst_q;
	always_ff @(posedge LINK_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			lrst_q <= 2'h3;
		end else begin
			lrst_q <= {lrst_q[0], 1'b0};
		end
	end
	logic lrst;
	assign lrst = lrst_q[1];

	// Levels into the link domain
	logic [1:0] lrun_sq, lcmd_sq, lsoff_sq, ldown_sq, lpd_sq;
	always_ff @(posedge LINK_CLK_I or posedge lrst) begin
		if (lrst) begin
			lrun_sq <= 2'h0;
			lcmd_sq <= 2'h0;
			lsoff_sq <= 2'h3;
			ldown_sq <= 2'h3;
			lpd_sq <= 2'h0;
		end else begin
			lrun_sq <= {lrun_sq[0], run_q};
			lcmd_sq <= {lcmd_sq[0], BUILT_IN_SELF_TEST_SER_CMD_O};
			lsoff_sq <= {lsoff_sq[0], !SER_STATE_O[1]};
			ldown_sq <= {ldown_sq[0], !LOCK_O};
			lpd_sq <= {lpd_sq[0], dpd_s};
		end
	end
	logic l_run, l_cmd, l_soff, l_down, l_pd;
	assign l_run = lrun_sq[1];
	assign l_cmd = lcmd_sq[1];
	assign l_soff = lsoff_sq[1];
	assign l_down = ldown_sq[1];
	assign l_pd = lpd_sq[1];

	// Serializer transmit word
	logic [14:0] gen_q;
	always_ff @(posedge LINK_CLK_I or posedge lrst) begin
		if (lrst) begin
			gen_q <= `SDBW_PRBS_SEED;
			SER_TX_WORD_O <= '1;
		end else begin
			gen_q <= l_cmd ? prbs_step(gen_q) : `SDBW_PRBS_SEED;
			if (l_soff) begin
				SER_TX_WORD_O <= '1;
			end else if (l_cmd) begin
				SER_TX_WORD_O <= DATA_W'({gen_q, gen_q});
			end else begin
				SER_TX_WORD_O <= SER_PAR_DATA_I;
			end
		end
	end

	// Checker: locks its own generator to the first received word after three skipped words of a session
	logic [14:0] chk_q;
	logic run_d_q, seeded_q, err_q, fail_q;
	logic [1:0] skip_q;
	logic [CNT_W-1:0] cnt_q, gray_q;
	logic [DATA_W-1:0] expect_w;
	assign expect_w = DATA_W'({chk_q, chk_q});
	always_ff @(posedge LINK_CLK_I or posedge lrst) begin
		if (lrst) begin
			chk_q <= `SDBW_PRBS_SEED;
			run_d_q <= 1'b0;
			seeded_q <= 1'b0;
			skip_q <= 2'h3;
			err_q <= 1'b0;
			fail_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			run_d_q <= l_run;
			err_q <= 1'b0;
			if (!l_pd || (l_run && !run_d_q)) begin
				seeded_q <= 1'b0;
				skip_q <= 2'h3;
				fail_q <= 1'b0;
				cnt_q <= '0;
			end else if (l_run) begin
				if (skip_q != 2'h0) begin
					// Words still in flight from before the session would seed a wrong pattern
					skip_q <= skip_q - 2'h1;
				end else if (!seeded_q) begin
					seeded_q <= 1'b1;
					chk_q <= prbs_step(LINK_WORD_I[14:0]);
				end else begin
					chk_q <= prbs_step(chk_q);
					if (LINK_WORD_I != expect_w) begin
						err_q <= 1'b1;
						fail_q <= 1'b1;
						if (cnt_q != '1) begin
							cnt_q <= cnt_q + 1'b1;
						end
					end
				end
			end
		end
	end

	// Half-cycle fail pulses: toggle on rising edge, follow on falling edge
	logic tog_p_q, tog_n_q;
	always_ff @(posedge LINK_CLK_I or posedge lrst) begin
		if (lrst) begin
			tog_p_q <= 1'b0;
		end else if (err_q) begin
			tog_p_q <= !tog_p_q;
		end
	end
	always_ff @(negedge LINK_CLK_I or posedge lrst) begin
		if (lrst) begin
			tog_n_q <= 1'b0;
		end else begin
			tog_n_q <= tog_p_q;
		end
	end
	// The pins differ only from a rising edge to the next falling edge
	assign PASS_O = run_d_q ? !(tog_p_q ^ tog_n_q) : !fail_q;

	// Error count crosses as gray code; it moves one step at a time between clears
	always_ff @(posedge LINK_CLK_I or posedge lrst) begin
		if (lrst) begin
			gray_q <= '0;
		end else begin
			gray_q <= cnt_q ^ (cnt_q >> 1);
		end
	end
	logic [CNT_W-1:0] gray_m_q, gray_s_q, bin_w;
	always_comb begin
		bin_w = '0;
		bin_w[CNT_W-1] = gray_s_q[CNT_W-1];
		for (int i = CNT_W - 2; i >= 0; i--) begin
			bin_w[i] = bin_w[i+1] ^ gray_s_q[i];
		end
	end
	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			gray_m_q <= '0;
			gray_s_q <= '0;
			ERR_COUNT_O <= '0;
		end else begin
			gray_m_q <= gray_q;
			gray_s_q <= gray_m_q;
			ERR_COUNT_O <= bin_w;
		end
	end

	// Deserializer parallel outputs; idle select 1 floats them, 0 drives low
	always_ff @(posedge LINK_CLK_I or posedge lrst) begin
		if (lrst) begin
			DES_PAR_DATA_O <= '0;
			DES_PAR_OE_O <= 1'b0;
		end else if (l_down) begin
			DES_PAR_DATA_O <= '0;
			DES_PAR_OE_O <= !OUTPUT_IDLE_STATE_SELECT_I;
		end else begin
			DES_PAR_DATA_O <= LINK_WORD_I;
			DES_PAR_OE_O <= 1'b1;
		end
	end

	// Checks
	wake_standby_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		(ser_q == SDBW_SER_ACT_PCLK || ser_q == SDBW_SER_ACT_OSC) && spd_s && !wake_lvl
		|=> ser_q == SDBW_SER_STANDBY ##1 SER_STATE_O == 2'h1)
		else $error("serializer did not return to standby");
	wake_active_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		ser_q == SDBW_SER_STANDBY && spd_s && wake_lvl |=> SER_STATE_O[1] == 1'b0 ##1 SER_STATE_O[1])
		else $error("serializer did not wake");
	osc_fallback_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		ser_q == SDBW_SER_ACT_PCLK && spd_s && wake_lvl && !pclk_s |=> ##1 SER_USE_OSC_O)
		else $error("no oscillator fallback");
	test_camera_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		!CAMERA_MODE_I |=> !run_q && !BUILT_IN_SELF_TEST_SER_CMD_O)
		else $error("self test outside camera mode");
	test_cmd_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		built_in_self_test_start |=> BUILT_IN_SELF_TEST_SER_CMD_O && BUILT_IN_SELF_TEST_CLK_SEL_O == $past(gin_s_q[1:0]))
		else $error("serializer test command or clock select missing");
	test_run_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		run_q |-> $past(built_in_self_test_s) && $past(des_q) == SDBW_DES_LOCKED)
		else $error("self test running without lock and pin");
	gpio_rate_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		$changed(GPIO_TO_SER_O) |-> rate_cnt_q == 12'h000)
		else $error("gpio forwarded too often");
	gpio_avail_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		##1 GPIO_AVAIL_O[5:2] == ($past(BUS_WIDTH_I) < 5'd12 ? 4'hf : 4'h0) && GPIO_AVAIL_O[1:0] == 2'h3)
		else $error("gpio availability wrong");
	pass_hold_a: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
		!l_run && l_pd |=> $stable(fail_q))
		else $error("pass result changed outside a session");
	drv_static_a: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
		l_soff |=> SER_TX_WORD_O == '1)
		else $error("driver not static high");
	count_step_a: assert property (@(posedge LINK_CLK_I) disable iff (lrst)
		l_pd && run_d_q && l_run && cnt_q != '1 && $past(LINK_WORD_I) != $past(expect_w) && $past(seeded_q)
		&& $past(l_run) && $past(run_d_q) |-> cnt_q == $past(cnt_q) + 1'b1)
		else $error("error count did not advance");
	test_seen_c: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) $rose(run_q) ##[1:400] !run_q);
	fail_seen_c: cover property (@(posedge LINK_CLK_I) disable iff (lrst) err_q ##1 err_q);
	osc_seen_c: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) ser_q == SDBW_SER_ACT_OSC);
	relock_c: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) $fell(LOCK_O) ##[1:100] LOCK_O);
endmodule // sdbw_pair_ctrl
`default_nettype wire

// ==== shared/sdbw_defs.svh ====
// Offsets, field positions, reset values and timing counts for the link self test and power control
`ifndef SDBW_DEFS_SVH
`define SDBW_DEFS_SVH
`define SDBW_REG_WAKE_OFS 8'h01
`define SDBW_REG_BCDRV_OFS 8'h26
`define SDBW_WAKE_BIT 2
`define SDBW_REG_WAKE_RST 8'h00
`define SDBW_REG_BCDRV_RST 8'h00
`define SDBW_CORE_MHZ 100
`define SDBW_GPIO_RATE_KHZ 66
`define SDBW_GPIO_CYC ((`SDBW_CORE_MHZ * 1000 + `SDBW_GPIO_RATE_KHZ - 1) / `SDBW_GPIO_RATE_KHZ)
`define SDBW_NARROW_BUS_BITS 12
`define SDBW_PRBS_SEED 15'h7fff
`endif

// ==== shared/sdbw_pkg.sv ====
// Types shared by the link self test and power control block
package sdbw_pkg;
	typedef enum logic [1:0] {
		SDBW_SER_OFF = 2'b00,
		SDBW_SER_STANDBY = 2'b01,
		SDBW_SER_ACT_PCLK = 2'b10,
		SDBW_SER_ACT_OSC = 2'b11
	} sdbw_ser_state_t;
	typedef enum logic [1:0] {
		SDBW_DES_OFF = 2'b00,
		SDBW_DES_DOWN = 2'b01,
		SDBW_DES_LOCKED = 2'b10
	} sdbw_des_state_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
	} sdbw_reg_req_t;
	typedef struct packed {
		logic [5:0] dir_out;
		logic [5:0] from_ser;
		logic [5:0] pin_in;
	} sdbw_gpio_t;
endpackage

// ==== sim/sdbw_pair_ctrl_test.sv ====
// Self-checking bench for the pair control block
`timescale 1ns/1ps
`default_nettype none
`include "sdbw_defs.svh"
module sdbw_pair_ctrl_test;
	import sdbw_pkg::*;
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic rst = 1'b1;
	sdbw_reg_req_t req = '0;
	sdbw_gpio_t gpio = '0;
	logic run_pin = 1'b0;
	logic des_pd_n = 1'b1;
	logic ser_pd_n = 1'b1;
	logic cam = 1'b1;
	logic [4:0] bw = 5'h10;
	logic oss = 1'b0;
	logic tedge = 1'b1;
	logic redge = 1'b1;
	logic pclk_ok = 1'b1;
	logic bc_err = 1'b0;
	logic stream_on = 1'b1;
	logic flip = 1'b0;
	logic [15:0] ser_data = 16'h0000;
	logic [15:0] link_word, tx_word, par_data;
	logic cdr_lock, lock, wake, ser_osc, cmd, ser_g0, s_rise, d_inv, par_oe, pass;
	logic [7:0] rdata, bc_mode, ser_errs, errs, r;
	logic [5:0] gpio_o, gpio_oe, gpio_av, gpio_fw;
	logic [1:0] ser_st, clk_sel;
	logic [15:0] lfsr_q = 16'h0062;
	int miscompares = 0;
	int total_checks = 0;
	int falls = 0;
	int widths[4] = '{8, 11, 12, 16};

	always #5 clk = ~clk;
	// Link clock also stands in for the external pixel clock of select 00
	always #7.5 lclk = ~lclk;
	always @(negedge pass) if (run_pin === 1'b1) falls++;

	sdbw_ser_model #(.DATA_W(16)) far (.link_clk_i(lclk), .stream_on_i(stream_on), .flip_i(flip),
		.tx_word_i(tx_word), .rx_word_o(link_word), .cdr_lock_o(cdr_lock));

	sdbw_pair_ctrl dut (.CORE_CLK_I(clk), .LINK_CLK_I(lclk), .SYS_RST_I(rst), .REG_REQ_I(req),
		.REG_RDATA_O(rdata), .SELF_TEST_RUN_PIN_I(run_pin), .DES_PWRDN_N_I(des_pd_n),
		.SER_PWRDN_N_I(ser_pd_n), .CAMERA_MODE_I(cam), .BUS_WIDTH_I(bw), .OUTPUT_IDLE_STATE_SELECT_I(oss),
		.SER_LATCH_EDGE_SELECT_I(tedge), .DES_STROBE_EDGE_SELECT_I(redge), .SER_PCLK_PRESENT_I(pclk_ok),
		.BC_ERR_I(bc_err), .GPIO_I(gpio), .GPIO_O(gpio_o), .GPIO_OE_O(gpio_oe), .GPIO_AVAIL_O(gpio_av),
		.GPIO_TO_SER_O(gpio_fw), .LOCK_O(lock), .REMOTE_WAKE_O(wake), .BC_DRV_MODE_O(bc_mode),
		.SER_STATE_O(ser_st), .SER_USE_OSC_O(ser_osc), .BUILT_IN_SELF_TEST_SER_CMD_O(cmd), .BUILT_IN_SELF_TEST_CLK_SEL_O(clk_sel),
		.SER_GPIO0_O(ser_g0), .SER_ERR_COUNT_O(ser_errs), .ERR_COUNT_O(errs), .SER_LATCH_RISE_O(s_rise),
		.DES_PCLK_INV_O(d_inv), .LINK_WORD_I(link_word), .LINK_CDR_LOCK_I(cdr_lock),
		.SER_PAR_DATA_I(ser_data), .SER_TX_WORD_O(tx_word), .DES_PAR_DATA_O(par_data),
		.DES_PAR_OE_O(par_oe), .PASS_O(pass));

	function automatic logic [15:0] rnd();
		lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		return lfsr_q;
	endfunction

	function automatic logic [5:0] avail(input logic [4:0] w);
		return (w < 5'd12) ? 6'h3f : 6'h03;
	endfunction

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Sample a little after the edge so its updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1};
		@(posedge clk) req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) req.addr <= a;
		cyc(2);
		d = rdata;
	endtask

	task automatic wait_lock();
		for (int i = 0; i < 300 && lock !== 1'b1; i++) cyc(1);
		chk("lock", 1'b1, lock);
	endtask

	task automatic flips(input int n);
		repeat (n) begin
			@(posedge lclk) flip <= 1'b1;
			@(posedge lclk) flip <= 1'b0;
			repeat (4) @(posedge lclk);
		end
	endtask

	task automatic session(input logic [1:0] sel, input int n);
		logic [7:0] b;
		@(posedge clk) gpio.pin_in[1:0] <= sel;
		cyc(2);
		falls = 0;
		@(posedge clk) run_pin <= 1'b1;
		cyc(8);
		chk("cmd", 1'b1, cmd);
		chk("clk sel", sel, clk_sel);
		cyc(40);
		chk("pass", 1'b1, pass);
		chk("errs", 16'h0000, errs);
		flips(n);
		b = ser_errs;
		@(posedge clk) bc_err <= 1'b1;
		cyc(3);
		chk("ser gpio0", 1'b0, ser_g0);
		@(posedge clk) bc_err <= 1'b0;
		cyc(30);
		chk("ser errs", 16'(b + 8'd4), ser_errs);
		chk("falls", 16'(n), 16'(falls));
		@(posedge clk) run_pin <= 1'b0;
		cyc(20);
		chk("errs", 16'(n), errs);
		chk("pass", n == 0, pass);
		flips(2);
		cyc(20);
		chk("late errs", 16'(n), errs);
		chk("pass held", n == 0, pass);
		$display("self test session %0d done", sel);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		#400000;
		miscompares++;
		complete_run();
	end

	initial begin
		ser_data = rnd();
		repeat (2) @(posedge clk);
		@(posedge clk) rst <= 1'b0;
		cyc(2);
		rd(`SDBW_REG_WAKE_OFS, r);
		chk("wake reg", `SDBW_REG_WAKE_RST, r);
		rd(`SDBW_REG_BCDRV_OFS, r);
		chk("drv reg", `SDBW_REG_BCDRV_RST, r);
		chk("ser state", SDBW_SER_STANDBY, ser_st);
		chk("pass", 1'b1, pass);
		wr(8'h26, 8'hc0);
		rd(8'h26, r);
		chk("drv reg", 8'hc0, r);
		chk("drv mode", 8'hc0, bc_mode);
		wr(8'h01, 8'h04);
		cyc(6);
		chk("wake", 1'b1, wake);
		chk("ser state", SDBW_SER_ACT_PCLK, ser_st);
		wr(8'h26, 8'h00);
		wr(8'h55, 8'haa);
		rd(8'h55, r);
		chk("unmapped", 8'h00, r);
		@(posedge clk) pclk_ok <= 1'b0;
		cyc(8);
		chk("ser state", SDBW_SER_ACT_OSC, ser_st);
		chk("ser osc", 1'b1, ser_osc);
		@(posedge clk) pclk_ok <= 1'b1;
		cyc(8);
		chk("ser osc", 1'b0, ser_osc);
		wr(8'h01, 8'h00);
		cyc(10);
		chk("ser state", SDBW_SER_STANDBY, ser_st);
		chk("tx idle", 16'hffff, tx_word);
		@(posedge clk) cam <= 1'b0;
		wr(8'h01, 8'h04);
		cyc(6);
		chk("wake", 1'b0, wake);
		@(posedge clk) cam <= 1'b1;
		cyc(8);
		chk("ser state", SDBW_SER_ACT_PCLK, ser_st);
		$display("register and wake test done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) {tedge, redge} <= 2'(i);
			cyc(4);
			chk("latch rise", tedge, s_rise);
			chk("pclk inv", !redge, d_inv);
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) bw <= 5'(widths[i]);
			cyc(3);
			chk("avail", avail(5'(widths[i])), gpio_av);
		end
		@(posedge clk) begin
			bw <= 5'd10;
			gpio.dir_out <= 6'h3f;
			gpio.from_ser <= 6'(rnd());
		end
		cyc(4);
		chk("gpio out", gpio.from_ser & avail(bw), gpio_o);
		chk("gpio oe", avail(bw), gpio_oe);
		@(posedge clk) begin
			gpio.dir_out <= 6'h00;
			gpio.pin_in <= 6'(rnd());
		end
		cyc(`SDBW_GPIO_CYC + 20);
		chk("gpio fwd", gpio.pin_in, gpio_fw);
		$display("edge and gpio test done");
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) begin
				stream_on <= 1'b0;
				oss <= i[0];
			end
			cyc(12);
			chk("lock", 1'b0, lock);
			chk("par oe", !oss, par_oe);
			if (i == 0) chk("par data", 16'h0000, par_data);
			@(posedge clk) stream_on <= 1'b1;
			wait_lock();
		end
		@(posedge clk) ser_pd_n <= 1'b0;
		cyc(10);
		chk("tx idle", 16'hffff, tx_word);
		@(posedge clk) ser_pd_n <= 1'b1;
		cyc(10);
		chk("ser state", SDBW_SER_ACT_PCLK, ser_st);
		cyc(6);
		chk("tx data", ser_data, tx_word);
		chk("par data", ser_data, par_data);
		$display("power test done");
		@(posedge clk) cam <= 1'b0;
		@(posedge clk) run_pin <= 1'b1;
		cyc(8);
		chk("cmd", 1'b0, cmd);
		@(posedge clk) run_pin <= 1'b0;
		// Pin must be low past its synchroniser, or camera mode brings a stray command
		cyc(3);
		@(posedge clk) cam <= 1'b1;
		wait_lock();
		session(2'b00, 0);
		for (int s = 1; s < 4; s++) session(2'(s), 1 + int'(rnd() % 16'd3));
		@(posedge clk) des_pd_n <= 1'b0;
		cyc(4);
		@(posedge clk) des_pd_n <= 1'b1;
		wait_lock();
		// Count needs a link crossing and three core flops to settle
		cyc(10);
		chk("pass cleared", 1'b1, pass);
		chk("errs cleared", 16'h0000, errs);
		complete_run();
	end
endmodule // sdbw_pair_ctrl_test
`default_nettype wire

// ==== sim/sdbw_ser_model.sv ====
// Behavioural remote serializer: carries the transmit word back over the link
`timescale 1ns/1ps
`default_nettype none
module sdbw_ser_model #(
	parameter int DATA_W = 16
) (
	// Link side
	input wire logic link_clk_i,
	input wire logic stream_on_i,
	input wire logic flip_i,
	input wire logic [DATA_W-1:0] tx_word_i,
	output logic [DATA_W-1:0] rx_word_o,
	output logic cdr_lock_o
);
	logic [DATA_W-1:0] last_q = '0;
	// A stopped stream shows a changing pattern, never a stale word
	always @(posedge link_clk_i) begin
		last_q <= stream_on_i ? (tx_word_i ^ DATA_W'(flip_i)) : ~last_q;
	end
	assign rx_word_o = last_q;
	assign cdr_lock_o = stream_on_i;
endmodule // sdbw_ser_model
`default_nettype wire
